// *** core/afc_codec.sv ***
// audio sample fifos with a sector encoder on the transmit path and a
// decoder on the receive path, registers on apb
// assumes sample_tick and rx_strobe come from logic on pclk
// one 32-bit word is one stereo pair, left in 31:16
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps

// What this block does
// R1: released transmit fifo stays held, one sample
// R2: first write releases hold, starts transmission
// R3: each fifo holds at most six entries
// R4: empty flag when one sample remains
// R5: underrun flag, last sample repeated
// R6: tick flag after programmed sample pairs
// R7: receive fifo leaves reset only by software
// R8: software resets, releases fifos, then enables tick
// R9: software write jitter under one sample
// R10: swap field reorders each 32-bit word
// R11: sync enable recognises sector sync sequences
// R12: otherwise next block one sector later
// R13: decoder enable turns descrambling on
// R14: decoder mode selects crc check
// R15: encoder enable turns scrambling on
// R16: encoder mode selects crc insertion
// R17: inserted crc overwrites written data
// R18: decoder flags raised at fifo output
// R19: block start flag on first word
// R20: missing sync and bad length flags
// R21: crc failure flag at block start
// R22: encoder order crc, scramble, swap
module afc_codec
   import afc_pkg::*;
#(
   parameter int DEPTH = 6
) (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input logic sample_tick,
   input logic rx_strobe,
   input logic [31:0] rx_sample,
   output logic [31:0] tx_sample,
   output logic tx_running
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [15:0] ctrl;
      logic tx_rst;
      logic rx_rst;
      logic [AFC_TICK_W-1:0] tick_n;
      logic [AFC_TICK_W-1:0] tick_cnt;
      logic held;
      logic running;
      logic [DEPTH-1:0][31:0] tx_mem;
      logic [PW-1:0] tx_wp;
      logic [PW-1:0] tx_rp;
      logic [CW-1:0] tx_cnt;
      logic [DEPTH-1:0][35:0] rx_mem;
      logic [PW-1:0] rx_wp;
      logic [PW-1:0] rx_rp;
      logic [CW-1:0] rx_cnt;
      logic [31:0] tx_out;
      logic [AFC_STAT_W-1:0] stat;
      afc_path_t enc;
      afc_path_t dec;
      logic rd_valid;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } afc_state_t;

   afc_state_t q;
   afc_state_t next_q;

   // depth need not be a power of two, so pointers wrap by compare
   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // byte lanes of one pair, last on encode and first on decode
   function automatic logic [31:0] word_swap(input logic [31:0] w, input logic [1:0] c);
      logic [31:0] r;
      unique case (c)
         2'b00: r = w;
         2'b01: r = {w[15:0], w[31:16]};
         2'b10: r = {w[23:16], w[31:24], w[7:0], w[15:8]};
         default: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
      endcase
      return r;
   endfunction

   // first stream byte sits in bits 31:24, each byte lsb first
   function automatic logic [31:0] edc_word(input logic [31:0] c, input logic [31:0] w);
      logic [31:0] r;
      logic b;
      r = c;
      for (int i = 0; i < 32; i++) begin
         b = w[24 - 8 * (i / 8) + (i % 8)];
         r = {1'b0, r[31:1]} ^ ((r[0] ^ b) ? AFC_EDC_POLY : 32'h00000000);
      end
      return r;
   endfunction

   // scrambler x^15 + x + 1 from the block seed, lsb of each byte first
   // returns the advanced register above the scrambled word
   function automatic logic [46:0] scr_word(input logic [14:0] s, input logic [31:0] w);
      logic [14:0] r;
      logic [31:0] o;
      int k;
      r = s;
      o = w;
      for (int i = 0; i < 32; i++) begin
         k = 24 - 8 * (i / 8) + (i % 8);
         o[k] = w[k] ^ r[0];
         r = {r[0] ^ r[1], r[14:1]};
      end
      return {r, o};
   endfunction

   // one word through the block framing, crc and scrambler of a path
   function automatic afc_step_t path_step(input afc_path_t p, input logic [31:0] w,
                                           input logic sync_en, input logic scr_en,
                                           input logic [1:0] mode, input logic enc);
      afc_step_t r;
      logic hit;
      logic [AFC_POS_W-1:0] pos;
      logic [AFC_POS_W-1:0] crc_first;
      logic [AFC_POS_W-1:0] edc_at;
      logic [14:0] lfsr_in;
      logic [31:0] crc_in;
      logic [31:0] d;
      logic [46:0] sc;
      logic scr_on;
      r = '0;
      r.p = p;
      // sync seen on its third word, so block word three follows it
      hit = sync_en && p.s2 == AFC_SYNC0 && p.s1 == AFC_SYNC1 && w == AFC_SYNC2; // [R11]
      pos = hit ? AFC_FIRST_WORD - 1'b1 : p.pos;
      crc_first = (mode == AFC_MODE1) ? AFC_POS_W'(AFC_M1_START / 4)
                                      : AFC_POS_W'(AFC_M2_START / 4);
      unique case (mode)
         AFC_MODE1: edc_at = AFC_POS_W'(AFC_M1_EDC / 4);
         AFC_M2F1: edc_at = AFC_POS_W'(AFC_F1_EDC / 4);
         default: edc_at = AFC_POS_W'(AFC_F2_EDC / 4);
      endcase
      // block flags ride on the first word, not on the sync
      r.first = (pos == AFC_FIRST_WORD);
      lfsr_in = r.first ? AFC_LFSR_SEED : p.lfsr;
      if (r.first) begin
         r.missing_sync_flag = !p.seen; // [R20]
         r.badlen = (p.len != AFC_SECTOR_WORDS); // [R20]
         r.crcfail = p.fail; // [R21]
         r.p.seen = 1'b0;
         r.p.fail = 1'b0;
         r.p.len = AFC_POS_W'(1);
      end else if (p.len != '1) begin
         r.p.len = p.len + 1'b1;
      end
      if (hit) begin
         r.p.seen = 1'b1;
      end
      scr_on = scr_en && pos >= AFC_FIRST_WORD;
      // crc restarts at the first covered word of each block
      crc_in = (pos == crc_first) ? 32'h00000000 : p.crc;
      d = w;
      if (!enc && scr_on) begin
         sc = scr_word(lfsr_in, d); // [R13]
         d = sc[31:0];
      end
      // processor data in the crc slot is thrown away
      if (mode != AFC_NO_CRC && pos == edc_at) begin
         if (enc) begin
            d = {crc_in[7:0], crc_in[15:8], crc_in[23:16], crc_in[31:24]}; // [R16] [R17]
         end else if (d != {crc_in[7:0], crc_in[15:8], crc_in[23:16], crc_in[31:24]}) begin
            r.p.fail = 1'b1; // [R14]
         end
      end
      r.p.crc = hit ? edc_word(edc_word(edc_word(32'h00000000, AFC_SYNC0), AFC_SYNC1),
                               AFC_SYNC2)
                    : edc_word(crc_in, d);
      // register advances even with scrambling off, keeping its phase
      sc = scr_word(lfsr_in, d);
      if (enc && scr_on) begin
         d = sc[31:0]; // [R15] [R22]
      end
      r.p.lfsr = sc[46:32];
      r.p.s2 = p.s1;
      r.p.s1 = w;
      r.p.pos = (pos == AFC_SECTOR_WORDS - 1'b1) ? '0 : pos + 1'b1; // [R12]
      r.w = d;
      return r;
   endfunction

   logic acc_done;
   logic wr;
   logic rd;
   logic [31:0] rdv;
   logic [AFC_STAT_W-1:0] sset;
   logic [AFC_STAT_W-1:0] sclr;
   logic [CW-1:0] tcnt;
   logic [CW-1:0] rcnt;
   afc_step_t es;
   afc_step_t ds;
   logic [35:0] rhead;

   always_comb begin
      next_q = q;
      acc_done = psel & penable & q.pready;
      wr = acc_done & pwrite;
      rd = acc_done & ~pwrite;
      rdv = 32'h00000000;
      sset = '0;
      sclr = '0;
      tcnt = q.tx_cnt;
      rcnt = q.rx_cnt;
      rhead = q.rx_mem[q.rx_rp];
      // every access answers in its first access cycle
      next_q.pready = psel & ~penable;
      next_q.pslverr = 1'b0;
      if (psel & ~penable) begin
         next_q.rd_valid = 1'b0;
         unique case (paddr)
            AFC_OFF_CTRL: rdv[15:0] = q.ctrl;
            AFC_OFF_FIFO: begin
               rdv[AFC_TX_RST_BIT] = q.tx_rst;
               rdv[AFC_RX_RST_BIT] = q.rx_rst;
               rdv[AFC_TICK_LSB +: AFC_TICK_W] = q.tick_n;
            end
            AFC_OFF_STAT: begin
               rdv[AFC_STAT_W-1:0] = q.stat;
               rdv[AFC_ST_TXCNT_LSB +: CW] = q.tx_cnt;
               rdv[AFC_ST_RXCNT_LSB +: CW] = q.rx_cnt;
               rdv[AFC_ST_HELD_BIT] = q.held;
            end
            AFC_OFF_TXDATA: rdv = 32'h00000000;
            AFC_OFF_RXDATA: begin
               // head captured now, popped only when this same word was seen
               rdv = (q.rx_cnt != '0) ? rhead[31:0] : 32'h00000000;
               next_q.rd_valid = (q.rx_cnt != '0);
            end
            default: next_q.pslverr = 1'b1;
         endcase
         next_q.prdata = rdv;
      end
      // writes land at the access edge, together with pready
      if (wr) begin
         unique case (paddr)
            AFC_OFF_CTRL: next_q.ctrl = pwdata[15:0] & AFC_CTRL_MASK;
            AFC_OFF_FIFO: begin
               next_q.tx_rst = pwdata[AFC_TX_RST_BIT];
               next_q.rx_rst = pwdata[AFC_RX_RST_BIT]; // [R7]
               next_q.tick_n = pwdata[AFC_TICK_LSB +: AFC_TICK_W];
            end
            AFC_OFF_STAT: sclr = pwdata[AFC_STAT_W-1:0];
            AFC_OFF_TXDATA: sclr[AFC_ST_EMPTY] = 1'b1;
            default: ;
         endcase
      end

      // transmit side
      // encoder result only kept when the word is accepted
      es = path_step(q.enc, pwdata, q.ctrl[AFC_ENC_SYNC_BIT], q.ctrl[AFC_ENC_EN_BIT],
                     q.ctrl[AFC_ENC_MODE_LSB +: 2], 1'b1);
      if (q.tx_rst) begin
         // held in reset with one zero sample kept
         next_q.tx_mem[0] = 32'h00000000; // [R1]
         next_q.tx_rp = '0;
         next_q.tx_wp = PW'(1);
         next_q.tx_cnt = CW'(1);
         next_q.held = 1'b1; // [R1]
         next_q.running = 1'b0;
         next_q.enc = '0;
      end else begin
         // ticks before the first write are ignored, kept sample stays out
         if (sample_tick && q.running) begin
            if (q.tx_cnt != '0) begin
               next_q.tx_out = q.tx_mem[q.tx_rp];
               next_q.tx_rp = ptr_inc(q.tx_rp);
               tcnt = q.tx_cnt - 1'b1;
               sset[AFC_ST_EMPTY] = (tcnt == CW'(1)); // [R4]
            end else begin
               // tx_out kept, so the last sample goes out again
               sset[AFC_ST_UNDER] = 1'b1; // [R5]
            end
         end
         if (wr && paddr == AFC_OFF_TXDATA && tcnt != CW'(DEPTH)) begin // [R3]
            next_q.tx_mem[q.tx_wp] = word_swap(es.w, q.ctrl[AFC_ENC_SWAP_LSB +: 2]); // [R10] [R22]
            next_q.tx_wp = ptr_inc(q.tx_wp);
            next_q.enc = es.p;
            tcnt = tcnt + 1'b1; // [R2]
            next_q.held = 1'b0; // [R2]
            next_q.running = 1'b1; // [R2]
         end
         next_q.tx_cnt = tcnt;
      end

      // sample pair tick, only counting once the receive side is released
      if (q.rx_rst || q.tick_n == '0) begin // [R8]
         next_q.tick_cnt = '0;
      end else if (sample_tick) begin
         if (q.tick_cnt + 1'b1 == q.tick_n) begin
            sset[AFC_ST_TICK] = 1'b1; // [R6]
            next_q.tick_cnt = '0;
         end else begin
            next_q.tick_cnt = q.tick_cnt + 1'b1;
         end
      end

      // receive side
      // sync search runs on the swapped word
      ds = path_step(q.dec, word_swap(rx_sample, q.ctrl[AFC_DEC_SWAP_LSB +: 2]), // [R10]
                     q.ctrl[AFC_DEC_SYNC_BIT], q.ctrl[AFC_DEC_EN_BIT],
                     q.ctrl[AFC_DEC_MODE_LSB +: 2], 1'b0);
      if (q.rx_rst) begin
         next_q.rx_rp = '0;
         next_q.rx_wp = '0;
         next_q.rx_cnt = '0;
         next_q.dec = '0;
      end else begin
         // only a word shown at setup may be popped, else a read loses data
         if (rd && paddr == AFC_OFF_RXDATA && q.rd_valid && q.rx_cnt != '0) begin
            next_q.rx_rp = ptr_inc(q.rx_rp);
            rcnt = q.rx_cnt - 1'b1;
         end
         // a full fifo drops the incoming word
         if (rx_strobe && rcnt != CW'(DEPTH)) begin // [R3]
            next_q.rx_mem[q.rx_wp] = {ds.first, ds.missing_sync_flag, ds.badlen, ds.crcfail, ds.w};
            next_q.rx_wp = ptr_inc(q.rx_wp);
            next_q.dec = ds.p;
            rcnt = rcnt + 1'b1;
         end
         next_q.rx_cnt = rcnt;
         // flags follow the word at the read end, not the input
         if (q.rx_cnt != '0 && rhead[35]) begin // [R18]
            sset[AFC_ST_FIRST] = 1'b1; // [R19]
            sset[AFC_ST_MISSING_SYNC_FLAG] = rhead[34]; // [R20]
            sset[AFC_ST_BADLEN] = rhead[33]; // [R20]
            sset[AFC_ST_CRC] = rhead[32]; // [R21]
         end
      end
      // set wins over a clear in the same cycle
      next_q.stat = (q.stat & ~sclr) | sset;
   end

   // reset leaves both fifos in software reset, tx loads its kept sample next
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ctrl <= AFC_CTRL_RESET;
         q.tx_rst <= 1'b1;
         q.rx_rst <= 1'b1;
         q.held <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // every output straight from the state register
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign tx_sample = q.tx_out;
   assign tx_running = q.running;
endmodule

// *** shared/afc_pkg.sv ***
// constants and types for the audio sample fifo and sector codec block
// assumes a 32-bit apb master and byte addresses on paddr
package afc_pkg;
   // register byte offsets
   localparam logic [7:0] AFC_OFF_CTRL = 8'h00;
   localparam logic [7:0] AFC_OFF_FIFO = 8'h04;
   localparam logic [7:0] AFC_OFF_STAT = 8'h08;
   localparam logic [7:0] AFC_OFF_TXDATA = 8'h0c;
   localparam logic [7:0] AFC_OFF_RXDATA = 8'h10;
   // codec control fields
   localparam int AFC_DEC_SWAP_LSB = 14;
   localparam int AFC_DEC_SYNC_BIT = 13;
   localparam int AFC_DEC_EN_BIT = 11;
   localparam int AFC_DEC_MODE_LSB = 9;
   localparam int AFC_ENC_SWAP_LSB = 6;
   localparam int AFC_ENC_SYNC_BIT = 5;
   localparam int AFC_ENC_EN_BIT = 3;
   localparam int AFC_ENC_MODE_LSB = 1;
   localparam logic [15:0] AFC_CTRL_RESET = 16'h0000;
   localparam logic [15:0] AFC_CTRL_MASK = 16'heeee;
   // fifo control fields
   localparam int AFC_TX_RST_BIT = 0;
   localparam int AFC_RX_RST_BIT = 1;
   localparam int AFC_TICK_LSB = 8;
   localparam int AFC_TICK_W = 8;
   // status fields
   localparam int AFC_STAT_W = 7;
   localparam int AFC_ST_EMPTY = 0;
   localparam int AFC_ST_UNDER = 1;
   localparam int AFC_ST_TICK = 2;
   localparam int AFC_ST_FIRST = 3;
   localparam int AFC_ST_MISSING_SYNC_FLAG = 4;
   localparam int AFC_ST_BADLEN = 5;
   localparam int AFC_ST_CRC = 6;
   localparam int AFC_ST_TXCNT_LSB = 8;
   localparam int AFC_ST_RXCNT_LSB = 12;
   localparam int AFC_ST_HELD_BIT = 16;
   // sector geometry in bytes, positions counted in 32-bit words
   localparam int AFC_POS_W = 10;
   localparam int AFC_SECTOR_BYTES = 2352;
   localparam int AFC_SYNC_BYTES = 12;
   localparam int AFC_M1_START = 0;
   localparam int AFC_M1_EDC = 2064;
   localparam int AFC_M2_START = 16;
   localparam int AFC_F1_EDC = 2072;
   localparam int AFC_F2_EDC = 2348;
   localparam logic [AFC_POS_W-1:0] AFC_SECTOR_WORDS = AFC_POS_W'(AFC_SECTOR_BYTES / 4);
   localparam logic [AFC_POS_W-1:0] AFC_FIRST_WORD = AFC_POS_W'(AFC_SYNC_BYTES / 4);
   localparam logic [31:0] AFC_SYNC0 = 32'h00ffffff;
   localparam logic [31:0] AFC_SYNC1 = 32'hffffffff;
   localparam logic [31:0] AFC_SYNC2 = 32'hffffff00;
   localparam logic [14:0] AFC_LFSR_SEED = 15'h0001;
   localparam logic [31:0] AFC_EDC_POLY = 32'hd8018001;

   typedef enum logic [1:0] {
      AFC_NO_CRC = 2'b00,
      AFC_MODE1 = 2'b01,
      AFC_M2F1 = 2'b10,
      AFC_M2F2 = 2'b11
   } afc_mode_t;

   typedef struct packed {
      logic [AFC_POS_W-1:0] pos;
      logic [AFC_POS_W-1:0] len;
      logic [14:0] lfsr;
      logic [31:0] crc;
      logic [31:0] s1;
      logic [31:0] s2;
      logic seen;
      logic fail;
   } afc_path_t;

   typedef struct packed {
      afc_path_t p;
      logic [31:0] w;
      logic first;
      logic missing_sync_flag;
      logic badlen;
      logic crcfail;
   } afc_step_t;
endpackage

// *** verification/afc_audio_peer.sv ***
// serial audio side: word clock ticks and incoming receive words
// assumes requests from the bench arrive on pclk edges
`timescale 1ns/1ps
module afc_audio_peer #(
   parameter int GAP = 8
) (
   input logic pclk,
   input logic presetn,
   input logic tick_en,
   input logic send,
   input logic [31:0] word,
   output logic sample_tick,
   output logic heard_v,
   output logic rx_strobe,
   output logic [31:0] rx_sample
);
   int cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         sample_tick <= 1'b0;
         heard_v <= 1'b0;
         rx_strobe <= 1'b0;
         rx_sample <= 32'h0;
      end else begin
         // steady word clock while enabled
         cnt <= (tick_en && cnt < GAP - 1) ? cnt + 1 : 0;
         sample_tick <= tick_en && cnt == GAP - 1;
         // output word is due one edge after its tick
         heard_v <= sample_tick;
         rx_strobe <= send;
         // idle line never keeps the last word
         rx_sample <= send ? word : ~rx_sample;
      end
   end
endmodule

// *** verification/afc_codec_assertions.sv ***
// port assertions for the audio fifo and sector codec block
// assumes it is bound into afc_codec, one clock domain on pclk
`timescale 1ns/1ps
module afc_codec_chk
   import afc_pkg::*;
#(
   parameter int DEPTH = 6
) (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic sample_tick,
   input logic rx_strobe,
   input logic [31:0] rx_sample,
   input logic [31:0] tx_sample,
   input logic tx_running
);
   logic acc, wr_tx, rd_st, tx_rst, rx_rst;
   assign acc = psel && penable && pready;
   assign wr_tx = acc && pwrite && paddr == AFC_OFF_TXDATA;
   assign rd_st = acc && !pwrite && paddr == AFC_OFF_STAT;
   // mirror of the software reset bits, the ports alone cannot show them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_rst <= 1'b1;
         rx_rst <= 1'b1;
      end else if (acc && pwrite && paddr == AFC_OFF_FIFO) begin
         tx_rst <= pwdata[AFC_TX_RST_BIT];
         rx_rst <= pwdata[AFC_RX_RST_BIT];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error response");
   a_held_tx_still: assert property (!$past(tx_running) |-> $stable(tx_sample))
      else $error("output moved while held");
   a_first_write_starts: assert property (wr_tx && !tx_rst && !tx_running |=> tx_running)
      else $error("first write did not start");
   a_start_needs_write: assert property ($rose(tx_running) |-> $past(wr_tx))
      else $error("start without write");
   a_tx_moves_tick: assert property (!$stable(tx_sample) |-> $past(sample_tick))
      else $error("output changed without tick");
   a_fifo_depth_bound: assert property (rd_st |-> prdata[11:8] <= DEPTH && prdata[15:12] <= DEPTH)
      else $error("fifo count above depth");
   a_rx_stays_reset: assert property (rd_st && rx_rst |-> prdata[15:12] == 4'h0)
      else $error("rx fifo filled in reset");
endmodule
bind afc_codec afc_codec_chk #(.DEPTH(DEPTH)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sample_tick(sample_tick), .rx_strobe(rx_strobe), .rx_sample(rx_sample),
   .tx_sample(tx_sample), .tx_running(tx_running));

// *** verification/afc_codec_tb.sv ***
// self-checking bench for the audio fifo and sector codec block
// assumes afc_codec, the audio peer model and the bound checker
`timescale 1ns/1ps
module afc_codec_tb;
   import afc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic sample_tick, rx_strobe, tx_running, tick_en, send, heard_v;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, tx_sample, rx_sample, word, rd, seed, w;
   logic [31:0] q[7];
   int bad_count, n_compared, i;
   // first scrambler word of a block from seed 1, byte 12 in 31:24
   localparam logic [31:0] SCR_HEAD = 32'h01800060;
   afc_codec #(.DEPTH(6)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick), .rx_strobe(rx_strobe),
      .rx_sample(rx_sample), .tx_sample(tx_sample), .tx_running(tx_running));
   afc_audio_peer #(.GAP(8)) u_peer (.pclk(pclk), .presetn(presetn), .tick_en(tick_en),
      .send(send), .word(word), .sample_tick(sample_tick), .heard_v(heard_v),
      .rx_strobe(rx_strobe), .rx_sample(rx_sample));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] swp(input logic [31:0] d, input logic [1:0] c);
      case (c)
         2'b01: return {d[15:0], d[31:16]};
         2'b10: return {d[23:16], d[31:24], d[7:0], d[15:8]};
         2'b11: return {d[7:0], d[15:8], d[23:16], d[31:24]};
         default: return d;
      endcase
   endfunction
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic limit(input int n);
      if (n >= 60) begin
         bad_count++;
         $display("[FAIL] %0t wait ran out", $time);
         give_verdict();
      end
   endtask
   task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 60);
      limit(n);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic pop(input logic [31:0] exp);
      int n;
      n = 0;
      tick_en <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (heard_v !== 1'b1 && n < 60);
      limit(n);
      check(tx_sample, exp);
      tick_en <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic feed(input logic [31:0] v);
      word <= v;
      send <= 1'b1;
      @(posedge pclk);
      send <= 1'b0;
      @(posedge pclk);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, tick_en, send} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      word = 32'h0;
      bad_count = 0;
      n_compared = 0;
      seed = 32'd80828;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(1'b0, AFC_OFF_CTRL, 32'h0);
      check(rd, 32'(AFC_CTRL_RESET));
      for (i = 0; i < 4; i++) begin
         seed = nxt(seed);
         bus(1'b1, AFC_OFF_CTRL, seed);
         bus(1'b0, AFC_OFF_CTRL, 32'h0);
         check(rd, 32'(seed[15:0] & AFC_CTRL_MASK));
      end
      bus(1'b0, 8'h40, 32'h0);
      check({rd[30:0], err}, 32'h1);
      bus(1'b1, AFC_OFF_CTRL, 32'h0);
      bus(1'b1, AFC_OFF_FIFO, 32'h2);
      feed(seed);
      pop(32'h0);
      check(32'(tx_running), 32'h0);
      bus(1'b0, AFC_OFF_STAT, 32'h0);
      check(rd & 32'h1ff00, 32'h10100);
      // with the kept sample, the sixth and seventh writes meet a full fifo
      for (i = 0; i < 7; i++) begin
         seed = nxt(seed);
         q[i] = seed;
         bus(1'b1, AFC_OFF_TXDATA, seed);
      end
      check(32'(tx_running), 32'h1);
      bus(1'b0, AFC_OFF_STAT, 32'h0);
      check(rd & 32'h10f00, 32'h00600);
      pop(32'h0);
      for (i = 0; i < 4; i++) begin
         pop(q[i]);
         bus(1'b0, AFC_OFF_STAT, 32'h0);
         check(32'(rd[AFC_ST_EMPTY]), 32'(i == 3));
      end
      pop(q[4]);
      pop(q[4]);
      bus(1'b0, AFC_OFF_STAT, 32'h0);
      check(32'(rd[AFC_ST_UNDER]), 32'h1);
      for (i = 0; i < 4; i++) begin
         seed = nxt(seed);
         w = swp(seed, 2'(i));
         bus(1'b1, AFC_OFF_CTRL, 32'(i) << AFC_ENC_SWAP_LSB);
         bus(1'b1, AFC_OFF_TXDATA, seed);
         pop(w);
      end
      bus(1'b1, AFC_OFF_STAT, 32'h7f);
      bus(1'b1, AFC_OFF_FIFO, 32'h300);
      for (i = 1; i <= 3; i++) begin
         pop(w);
         bus(1'b0, AFC_OFF_STAT, 32'h0);
         check(32'(rd[AFC_ST_TICK]), 32'(i == 3));
      end
      // encoder: sync recognised, the word after it goes out scrambled
      bus(1'b1, AFC_OFF_CTRL, 32'h1 << AFC_ENC_SYNC_BIT);
      q[0] = AFC_SYNC0;
      q[1] = AFC_SYNC1;
      q[2] = AFC_SYNC2;
      seed = nxt(seed);
      q[3] = seed;
      for (i = 0; i < 3; i++) bus(1'b1, AFC_OFF_TXDATA, q[i]);
      bus(1'b1, AFC_OFF_CTRL, (32'h1 << AFC_ENC_SYNC_BIT) | (32'h1 << AFC_ENC_EN_BIT));
      bus(1'b1, AFC_OFF_TXDATA, q[3]);
      for (i = 0; i < 3; i++) pop(q[i]);
      pop(q[3] ^ SCR_HEAD);
      bus(1'b1, AFC_OFF_CTRL, (32'h1 << AFC_DEC_SYNC_BIT) | (32'h1 << AFC_DEC_EN_BIT));
      q[0] = AFC_SYNC0;
      q[1] = AFC_SYNC1;
      q[2] = AFC_SYNC2;
      q[3] = nxt(seed);
      for (i = 0; i < 4; i++) feed(q[i]);
      for (i = 0; i < 3; i++) begin
         bus(1'b0, AFC_OFF_RXDATA, 32'h0);
         check(rd, q[i]);
      end
      bus(1'b1, AFC_OFF_STAT, 32'h7f);
      bus(1'b0, AFC_OFF_STAT, 32'h0);
      check(rd & 32'h78, 32'h28);
      bus(1'b0, AFC_OFF_RXDATA, 32'h0);
      check(rd, q[3] ^ SCR_HEAD);
      give_verdict();
   end
endmodule
